// >>> hw/adc_ctl_pkg.sv
// constants for the converter control block: serial frame layout, the
// configuration register, soft reset codes and timing counts.
// assumes a single system clock domain; the serial link is sampled.
package adc_ctl_pkg;

	// ==================================================================
	// serial frame layout
	localparam int FRAME_BITS = 16;
	localparam int RW_BIT = 15;
	localparam int ADDR_MSB = 14;
	localparam int ADDR_LSB = 8;
	localparam int DATA_MSB = 7;

	// ==================================================================
	// general configuration register
	localparam logic [6:0] GEN_CFG_ADDR = 7'h06;
	localparam logic [7:0] GEN_CFG_RESET = 8'h80;
	localparam int SYNC_BIT = 7;
	localparam int ONE_SHOT_BIT = 4;
	localparam int RST_MSB = 1;
	localparam int RST_LSB = 0;
	localparam logic [1:0] RST_FIRST = 2'h3;
	localparam logic [1:0] RST_SECOND = 2'h2;

	// ==================================================================
	// fixed answers and timing counts
	localparam logic [15:0] POST_RESET_REPLY = 16'h0e00;
	localparam logic [15:0] IDLE_REPLY = 16'h0000;
	localparam int SYNC_OUT_CYCLES = 4;
	localparam int SETTLE_CYCLES = 64;

endpackage : adc_ctl_pkg

// >>> hw/bit_sync.sv
// two-stage synchroniser for a group of independent pin levels.
// assumes each bit is a slow level; no word coherence is promised.
`timescale 1ns/1ps
module bit_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_s;

	sync_s st_r;
	sync_s st_nxt;

	// ==================================================================
	// the first stage feeds only the second
	always_comb begin
		st_nxt.meta = async_i;
		st_nxt.stable = st_r.meta;
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= {INIT, INIT};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_o = st_r.stable;

endmodule : bit_sync

// >>> hw/settle_timer.sv
// holds data off for a fixed number of clocks after each filter reset.
// assumes restart_i is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
module settle_timer #(
	parameter int CYCLES = adc_ctl_pkg::SETTLE_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic restart_i,
	output logic hold_o
);

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);

	typedef struct packed {
		logic [CW-1:0] left;
		logic hold;
	} timer_s;

	timer_s st_r;
	timer_s st_nxt;

	// ==================================================================
	// a new restart reloads the full count, so back to back syncs extend it
	always_comb begin
		st_nxt = st_r;
		if (restart_i) begin
			st_nxt.left = LOAD;
			st_nxt.hold = 1'b1;
		end else if (st_r.left != '0) begin
			st_nxt.left = st_r.left - CW'(1);
			st_nxt.hold = (st_r.left != CW'(1));
		end else begin
			st_nxt.hold = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hold_o = st_r.hold;

endmodule : settle_timer

// >>> hw/adc_soft_reset_and_sync_ctrl.sv
// serial control port, two-step soft reset, software sync and one-shot
// control of a multichannel converter.
// assumes a 16-bit frame, serial clock idle high, data taken on its
// rising edge and driven on its falling edge; the serial clock must be
// at most an eighth of clk_sys_i. sync_out_b_o is routed to sync_in_b_i.
// frames with other than 16 serial clock rising edges are dropped whole;
// a soft reset does not cut a sync pulse that is already going out.
//
// What this block does
// - soft reset needs field write 11 then 10; a write of 00 or 01 in between cancels it.
// - finishing the reset sequence resets the core and all registers to default.
// - after soft reset, the next command is answered next frame with 0x0e00.
// - a software sync acts exactly like a pulse on the start pin.
// - software sync is taken after the last serial clock edge of the frame.
// - the sync is driven out on the sync output pin on the system clock.
// - each pulse seen on the sync input resets the digital filters.
// - after a sync filter reset, data is held off for the settling time.
// - in one-shot mode each sync input rising edge yields one conversion.
// - one-shot bit at 0 disables one-shot mode, at 1 enables it.
`timescale 1ns/1ps
module adc_soft_reset_and_sync_ctrl #(
	parameter int SETTLE_CYCLES = adc_ctl_pkg::SETTLE_CYCLES,
	parameter int SYNC_OUT_CYCLES = adc_ctl_pkg::SYNC_OUT_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic sclk_i,
	input wire logic cs_b_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	input wire logic start_b_i,
	input wire logic sync_in_b_i,
	output logic sync_out_b_o,
	output logic core_reset_o,
	output logic filter_reset_o,
	output logic data_hold_o,
	output logic convert_o,
	output logic one_shot_en_o
);

	localparam int BW = $clog2(adc_ctl_pkg::FRAME_BITS + 1);
	localparam logic [BW-1:0] FULL_FRAME = BW'(adc_ctl_pkg::FRAME_BITS);
	localparam int PW = $clog2(SYNC_OUT_CYCLES + 1);
	localparam logic [PW-1:0] PULSE_LOAD = PW'(SYNC_OUT_CYCLES);
	localparam int TX_MSB = adc_ctl_pkg::FRAME_BITS - 1;

	// ==================================================================
	// soft reset sequence: the first code arms it, only the second fires
	typedef enum logic [0:0] {
		SEQ_IDLE = 1'b0,
		SEQ_ARMED = 1'b1
	} seq_e;

	typedef struct packed {
		logic [BW-1:0] bitcnt;
		logic [TX_MSB:0] rx;
		logic [TX_MSB:0] tx;
		logic [TX_MSB:0] reply;
		logic [7:0] cfg;
		seq_e seq;
		logic overrun;
		logic rst_reply;
		logic [PW-1:0] pulse_left;
		logic sync_out_b;
		logic core_rst;
		logic filt_rst;
		logic conv;
		logic sclk_d;
		logic cs_b_d;
		logic sync_in_d;
		logic start_d;
		logic miso;
		logic miso_oe;
	} ctl_s;

	ctl_s st_r;
	ctl_s st_nxt;

	logic sclk_s;
	logic cs_b_s;
	logic mosi_s;
	logic start_b_s;
	logic sync_in_b_s;
	logic restart_settle;

	// ==================================================================
	// pin synchronisers; idle levels are high for all strobes
	bit_sync #(
		.WIDTH(5),
		.INIT(5'h1b)
	) u_pin_sync (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.async_i({sclk_i, cs_b_i, mosi_i, start_b_i, sync_in_b_i}),
		.sync_o({sclk_s, cs_b_s, mosi_s, start_b_s, sync_in_b_s})
	);

	// ==================================================================
	// data hold-off after a filter reset
	assign restart_settle = st_r.filt_rst;

	settle_timer #(
		.CYCLES(SETTLE_CYCLES)
	) u_settle (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.restart_i(restart_settle),
		.hold_o(data_hold_o)
	);

	// ==================================================================
	// register read decode, used for the reply word
	function automatic logic [15:0] read_word(input logic [6:0] addr, input logic [7:0] cfg);
		logic [15:0] w;
		w = adc_ctl_pkg::IDLE_REPLY;
		if (addr == adc_ctl_pkg::GEN_CFG_ADDR) begin
			w = {8'h00, cfg};
		end
		return w;
	endfunction : read_word

	// ==================================================================
	// edge finders on a synchronised level and its copy one clock older
	function automatic logic went_high(input logic lvl, input logic prev);
		return lvl && !prev;
	endfunction : went_high

	function automatic logic went_low(input logic lvl, input logic prev);
		return !lvl && prev;
	endfunction : went_low

	// a given reset code written to the configuration register
	function automatic logic field_is(input logic hit, input logic [1:0] field,
			input logic [1:0] code);
		return hit && (field == code);
	endfunction : field_is

	// ==================================================================
	// frame handling, soft reset, sync generation and sync input
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic sync_in_rise;
	logic start_fall;
	logic frame_ok;
	logic is_write;
	logic [6:0] frame_addr;
	logic [7:0] frame_data;
	logic [1:0] rst_field;
	logic sw_sync;
	logic cfg_hit;
	logic first_code;
	logic second_code;
	logic soft_rst;

	always_comb begin
		st_nxt = st_r;
		sclk_rise = went_high(sclk_s, st_r.sclk_d);
		sclk_fall = went_low(sclk_s, st_r.sclk_d);
		cs_fall = went_low(cs_b_s, st_r.cs_b_d);
		cs_rise = went_high(cs_b_s, st_r.cs_b_d);
		sync_in_rise = went_high(sync_in_b_s, st_r.sync_in_d);
		start_fall = went_low(start_b_s, st_r.start_d);
		frame_ok = cs_rise;
		if (st_r.bitcnt != FULL_FRAME || st_r.overrun) begin
			frame_ok = 1'b0;
		end
		is_write = !st_r.rx[adc_ctl_pkg::RW_BIT];
		frame_addr = st_r.rx[adc_ctl_pkg::ADDR_MSB:adc_ctl_pkg::ADDR_LSB];
		frame_data = st_r.rx[adc_ctl_pkg::DATA_MSB:0];
		rst_field = frame_data[adc_ctl_pkg::RST_MSB:adc_ctl_pkg::RST_LSB];
		cfg_hit = is_write && (frame_addr == adc_ctl_pkg::GEN_CFG_ADDR);
		first_code = field_is(cfg_hit, rst_field, adc_ctl_pkg::RST_FIRST);
		second_code = field_is(cfg_hit, rst_field, adc_ctl_pkg::RST_SECOND);
		sw_sync = 1'b0;
		soft_rst = 1'b0;

		st_nxt.sclk_d = sclk_s;
		st_nxt.cs_b_d = cs_b_s;
		st_nxt.sync_in_d = sync_in_b_s;
		st_nxt.start_d = start_b_s;
		st_nxt.core_rst = 1'b0;
		st_nxt.filt_rst = 1'b0;
		st_nxt.conv = 1'b0;

		// serial shifter: load the pending reply at frame start
		if (cs_fall) begin
			st_nxt.bitcnt = '0;
			st_nxt.tx = st_r.reply;
			st_nxt.miso = st_r.reply[TX_MSB];
			st_nxt.miso_oe = 1'b1;
			st_nxt.overrun = 1'b0;
		end else if (!cs_b_s) begin
			// a seventeenth rising edge spoils the frame rather than being dropped
			if (sclk_rise) begin
				if (st_r.bitcnt == FULL_FRAME) begin
					st_nxt.overrun = 1'b1;
				end else begin
					st_nxt.rx = {st_r.rx[TX_MSB-1:0], mosi_s};
					st_nxt.bitcnt = st_r.bitcnt + BW'(1);
				end
			end
			if (sclk_fall && st_r.bitcnt != '0) begin
				st_nxt.tx = {st_r.tx[TX_MSB-1:0], 1'b0};
				st_nxt.miso = st_r.tx[TX_MSB-1];
			end
		end
		if (cs_rise) begin
			st_nxt.miso_oe = 1'b0;
			st_nxt.miso = 1'b0;
		end

		// short frames are dropped whole; the command runs at frame end,
		// which is after the last serial clock edge
		if (frame_ok) begin
			if (st_r.rst_reply) begin
				st_nxt.reply = adc_ctl_pkg::POST_RESET_REPLY;
				st_nxt.rst_reply = 1'b0;
			end else if (is_write) begin
				st_nxt.reply = adc_ctl_pkg::IDLE_REPLY;
			end else begin
				st_nxt.reply = read_word(frame_addr, st_r.cfg);
			end
			if (is_write) begin
				case (st_r.seq)
					SEQ_IDLE: begin
						if (first_code) begin
							st_nxt.seq = SEQ_ARMED;
						end
					end
					SEQ_ARMED: begin
						if (second_code) begin
							st_nxt.seq = SEQ_IDLE;
							soft_rst = 1'b1;
						end else if (!first_code) begin
							// a repeated first code keeps the sequence armed
							st_nxt.seq = SEQ_IDLE;
						end
					end
					default: begin
						st_nxt.seq = SEQ_IDLE;
					end
				endcase
				// the write that completes a soft reset stores nothing
				if (cfg_hit && !soft_rst) begin
					st_nxt.cfg = frame_data;
					// only a low to high change of the stored bit counts
					if (!st_r.cfg[adc_ctl_pkg::SYNC_BIT] && frame_data[adc_ctl_pkg::SYNC_BIT]) begin
						sw_sync = 1'b1;
					end
				end
				if (soft_rst) begin
					st_nxt.cfg = adc_ctl_pkg::GEN_CFG_RESET;
					st_nxt.core_rst = 1'b1;
					st_nxt.rst_reply = 1'b1;
					st_nxt.reply = adc_ctl_pkg::IDLE_REPLY;
				end
			end
		end

		// software sync and the start pin share one path
		if (sw_sync || start_fall) begin
			st_nxt.pulse_left = PULSE_LOAD;
			st_nxt.sync_out_b = 1'b0;
		end else if (st_r.pulse_left != '0) begin
			st_nxt.pulse_left = st_r.pulse_left - PW'(1);
			st_nxt.sync_out_b = (st_r.pulse_left == PW'(1));
		end else begin
			st_nxt.sync_out_b = 1'b1;
		end

		// the end of a sync input pulse resets filters and, in one-shot
		// mode, starts a single conversion
		if (sync_in_rise) begin
			st_nxt.filt_rst = 1'b1;
			st_nxt.conv = st_r.cfg[adc_ctl_pkg::ONE_SHOT_BIT];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= '0;
			st_r.cfg <= adc_ctl_pkg::GEN_CFG_RESET;
			st_r.sync_out_b <= 1'b1;
			st_r.sclk_d <= 1'b1;
			st_r.cs_b_d <= 1'b1;
			st_r.sync_in_d <= 1'b1;
			st_r.start_d <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==================================================================
	// outputs, all straight from flip-flops
	assign miso_o = st_r.miso;
	assign miso_oe_o = st_r.miso_oe;
	assign sync_out_b_o = st_r.sync_out_b;
	assign core_reset_o = st_r.core_rst;
	assign filter_reset_o = st_r.filt_rst;
	assign convert_o = st_r.conv;
	assign one_shot_en_o = st_r.cfg[adc_ctl_pkg::ONE_SHOT_BIT];

endmodule : adc_soft_reset_and_sync_ctrl

// >>> test/adc_ctrl_monitor.sv
// checker for the converter control block: pulse widths, causes and holds.
// assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module adc_ctrl_monitor #(
	parameter int SETTLE_CYCLES = adc_ctl_pkg::SETTLE_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic sync_in_b_i,
	input wire logic sync_out_b_o,
	input wire logic core_reset_o,
	input wire logic filter_reset_o,
	input wire logic data_hold_o,
	input wire logic convert_o,
	input wire logic one_shot_en_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	// ================================================================
	// hold length counter, restarted by every filter reset
	int hold_cnt_r;
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hold_cnt_r <= 0;
		end else if (filter_reset_o) begin
			hold_cnt_r <= 0;
		end else begin
			hold_cnt_r <= hold_cnt_r + int'(data_hold_o);
		end
	end
	// ================================================================
	// properties
	property p_core_pulse; core_reset_o |=> !core_reset_o; endproperty
	a_core_pulse: assert property (p_core_pulse)
		else $error("core reset longer than one cycle");
	property p_core_dflt; core_reset_o |=> !one_shot_en_o; endproperty
	a_core_dflt: assert property (p_core_dflt)
		else $error("config not back to default after soft reset");
	property p_sync_len;
		$fell(sync_out_b_o) |-> !sync_out_b_o [*4] ##1 sync_out_b_o;
	endproperty
	a_sync_len: assert property (p_sync_len)
		else $error("sync output low time wrong");
	property p_filt_cause; $rose(sync_in_b_i) |-> ##[1:4] filter_reset_o; endproperty
	a_filt_cause: assert property (p_filt_cause)
		else $error("sync input edge gave no filter reset");
	property p_hold_follow; filter_reset_o |-> ##[1:2] data_hold_o; endproperty
	a_hold_follow: assert property (p_hold_follow)
		else $error("data not held after filter reset");
	property p_hold_len; $fell(data_hold_o) |-> hold_cnt_r == SETTLE_CYCLES; endproperty
	a_hold_len: assert property (p_hold_len)
		else $error("data hold length wrong");
	property p_conv_gate; convert_o |-> filter_reset_o && one_shot_en_o; endproperty
	a_conv_gate: assert property (p_conv_gate)
		else $error("conversion without one-shot sync");
	property p_conv_req; filter_reset_o && one_shot_en_o |-> convert_o; endproperty
	a_conv_req: assert property (p_conv_req)
		else $error("one-shot sync gave no conversion");
	c_soft_reset: cover property (core_reset_o);
	c_convert: cover property (convert_o);
	c_sync_out: cover property ($fell(sync_out_b_o));
endmodule : adc_ctrl_monitor

bind adc_soft_reset_and_sync_ctrl adc_ctrl_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_mon (
	.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sync_in_b_i(sync_in_b_i),
	.sync_out_b_o(sync_out_b_o), .core_reset_o(core_reset_o),
	.filter_reset_o(filter_reset_o), .data_hold_o(data_hold_o),
	.convert_o(convert_o), .one_shot_en_o(one_shot_en_o));

// >>> test/spi_master_model.sv
// serial master model: 16-bit mode 3 frames, clock idle high, 400 ns period.
// assumes the caller leaves at least one frame gap between calls.
`timescale 1ns/1ps
module spi_master_model (
	input wire logic clk_sys_i,
	input wire logic miso_i,
	output logic sclk_o,
	output logic cs_b_o,
	output logic mosi_o
);
	initial begin
		sclk_o = 1'b1;
		cs_b_o = 1'b1;
		mosi_o = 1'b0;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : cyc
	// ================================================================
	// one whole frame; data out is turned over after the frame so a stale
	// level is never mistaken for a driven one
	// a frame other than 16 bits long sends the word from its top bit, cut short or padded with zeros at the end
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx, input int nbits = 16);
		cs_b_o = 1'b0;
		cyc(4);
		for (int i = nbits - 1; i >= 0; i--) begin
			int k;
			k = i + 16 - nbits;
			sclk_o = 1'b0;
			mosi_o = (k >= 0) ? tx[k[3:0]] : 1'b0;
			cyc(4);
			if (k >= 0) begin
				rx[k[3:0]] = miso_i;
			end
			sclk_o = 1'b1;
			cyc(4);
		end
		cs_b_o = 1'b1;
		mosi_o = ~mosi_o;
		cyc(10);
	endtask : xfer
endmodule : spi_master_model

// >>> test/testbench.sv
// self-checking bench for the converter control block.
// assumes sync out is looped to sync in on the board, as in the system.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
	$display("wrong value at %0t: %h expected %h", $time, (a), (b)); end end
module testbench;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic start_b = 1'b1;
	logic sync_ext_b = 1'b1;
	localparam int SETTLE = 8;
	logic sclk;
	logic cs_b;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic miso_pin;
	logic sync_out_b;
	logic sync_in_b;
	logic core_rst;
	logic filt_rst;
	logic hold;
	logic conv;
	logic os_en;
	int errors = 0;
	int compares = 0;
	int n_conv, n_filt, n_core, n_sync, n_hold;
	logic [15:0] rx;
	// the board loops sync out back to sync in; a released data line is pulled high
	assign sync_in_b = sync_out_b & sync_ext_b;
	assign miso_pin = miso_oe ? miso : 1'b1;
	always #25 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		n_conv += int'(conv);
		n_filt += int'(filt_rst);
		n_core += int'(core_rst);
		n_sync += int'(!sync_out_b);
		n_hold += int'(hold);
	end
	adc_soft_reset_and_sync_ctrl #(.SETTLE_CYCLES(SETTLE)) dut (.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i), .sclk_i(sclk), .cs_b_i(cs_b), .mosi_i(mosi), .miso_o(miso),
		.miso_oe_o(miso_oe), .start_b_i(start_b), .sync_in_b_i(sync_in_b),
		.sync_out_b_o(sync_out_b), .core_reset_o(core_rst), .filter_reset_o(filt_rst),
		.data_hold_o(hold), .convert_o(conv), .one_shot_en_o(os_en));
	spi_master_model m (.clk_sys_i(clk_sys_i), .miso_i(miso_pin), .sclk_o(sclk),
		.cs_b_o(cs_b), .mosi_o(mosi));
	// ================================================================
	// helpers
	task automatic wr(input logic [7:0] d);
		m.xfer({1'b0, adc_ctl_pkg::GEN_CFG_ADDR, d}, rx);
	endtask : wr
	task automatic rd();
		m.xfer({1'b1, adc_ctl_pkg::GEN_CFG_ADDR, 8'h00}, rx);
	endtask : rd
	task automatic clr();
		m.cyc(24);
		{n_conv, n_filt, n_core, n_sync, n_hold} = '0;
	endtask : clr
	task automatic sync_pulse();
		sync_ext_b = 1'b0;
		m.cyc(4);
		sync_ext_b = 1'b1;
		m.cyc(24);
	endtask : sync_pulse
	// ================================================================
	// scenarios
	task automatic t_reset();
		`CHK(os_en, 1'b0)
		`CHK(miso_oe, 1'b0)
		fork
			rd();
			begin
				m.cyc(20);
				`CHK(miso_oe, 1'b1)
			end
		join
		`CHK(miso_oe, 1'b0)
		rd();
		`CHK(rx, {8'h00, adc_ctl_pkg::GEN_CFG_RESET})
	endtask : t_reset
	task automatic t_one_shot();
		clr();
		wr(8'h90);
		`CHK(os_en, 1'b1)
		sync_pulse();
		`CHK(n_conv, 1)
		`CHK(n_hold, SETTLE)
		`CHK(hold, 1'b0)
		`CHK(n_filt, 1)
		wr(8'h80);
		clr();
		sync_pulse();
		`CHK(n_conv, 0)
	endtask : t_one_shot
	task automatic t_sw_sync();
		clr();
		wr(8'h00);
		`CHK(n_sync, 0)
		wr(8'h80);
		m.cyc(24);
		`CHK(n_sync, 4)
		`CHK(n_filt, 1)
		wr(8'h00);
		wr(8'h80);
		m.cyc(24);
		`CHK(n_sync, 8)
		clr();
		start_b = 1'b0;
		m.cyc(4);
		start_b = 1'b1;
		m.cyc(24);
		`CHK(n_sync, 4)
		`CHK(n_filt, 1)
	endtask : t_sw_sync
	task automatic t_soft_reset();
		clr();
		wr(8'h93);
		wr(8'h91);
		wr(8'h92);
		`CHK(n_core, 0)
		wr(8'h93);
		m.xfer({1'b0, adc_ctl_pkg::GEN_CFG_ADDR, 8'h92}, rx, 15);
		m.xfer({1'b0, adc_ctl_pkg::GEN_CFG_ADDR, 8'h92}, rx, 17);
		`CHK(n_core, 0)
		wr(8'h92);
		m.cyc(4);
		`CHK(n_core, 1)
		`CHK(os_en, 1'b0)
		rd();
		rd();
		`CHK(rx, adc_ctl_pkg::POST_RESET_REPLY)
		rd();
		`CHK(rx, {8'h00, adc_ctl_pkg::GEN_CFG_RESET})
	endtask : t_soft_reset
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		#1_000_000;
		errors++;
		wrap_up();
	end
	initial begin
		m.cyc(16);
		rst_b_i = 1'b1;
		m.cyc(4);
		t_reset();
		t_one_shot();
		t_sw_sync();
		t_soft_reset();
		wrap_up();
	end
endmodule : testbench
